// ### common/mrl_pkg.sv
// Constants and types for the multi-register load sequencer
`default_nettype none
package mrl_pkg;
	localparam logic [5:0] OP_PRIMARY_X  = 6'h1f;
	localparam logic [5:0] OP_LOAD_MULTI = 6'h2e;
	localparam logic [9:0] XO_STR_IMM    = 10'h255;
	localparam logic [9:0] XO_STR_IDX    = 10'h215;
	localparam logic [9:0] XO_LOAD_RSV   = 10'h014;
	localparam logic [5:0] STR_IMM_ZERO_CNT = 6'h20;
	localparam logic [4:0] LAST_GPR      = 5'h1f;
	localparam int         FIFO_DEPTH    = 8;
	localparam int         FIFO_WIDTH    = 32;
	typedef enum logic [2:0] {
		EXC_NONE,
		EXC_ALIGN,
		EXC_DSTORAGE,
		EXC_DTLB,
		EXC_MCHECK
	} exc_t;
endpackage
`default_nettype wire

// ### rtl/mrl_fifo.sv
// Word FIFO between data port and register write path
`default_nettype none
module mrl_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 8
) (
	input  wire logic             clk_sys_i,
	input  wire logic             rst_b_i,
	input  wire logic             flush_i,
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	input  wire logic [WIDTH-1:0] in_data_i,
	output logic                  out_valid_o,
	input  wire logic             out_ready_i,
	output logic      [WIDTH-1:0] out_data_o
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0]    wr_q;
	logic [AW-1:0]    rd_q;
	logic [AW:0]      cnt_q;
	wire push = in_valid_i && in_ready_o;
	wire pop  = out_valid_o && out_ready_i;
	assign in_ready_o  = (cnt_q != (AW+1)'(DEPTH));
	assign out_valid_o = (cnt_q != '0);
	assign out_data_o  = mem_q[rd_q];
	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			wr_q  <= '0;
			rd_q  <= '0;
			cnt_q <= '0;
		end else if (flush_i) begin
			wr_q  <= '0;
			rd_q  <= '0;
			cnt_q <= '0;
		end else begin
			if (push) wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
			if (pop) rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
			cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
	always_ff @(posedge clk_sys_i) begin
		if (push) mem_q[wr_q] <= in_data_i;
	end
	chk_fifo_no_overflow: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		cnt_q == (AW+1)'(DEPTH) |-> !in_ready_o) else $error("fifo accepts while full");
endmodule // mrl_fifo
`default_nettype wire

// ### rtl/multi_register_load_sequencer.sv
// Multi-register and reserve load sequencer
// What this block does
// - Load-multiple address is sign-extended displacement plus base, or zero base.
// - Load-multiple reads 32 minus target words, address step four, to register 31.
// - Word for base register in range is dropped; register 31 always written.
// - Immediate string address is base contents alone, zero for field zero.
// - Immediate byte count field zero means 32 bytes.
// - String fills ceil(count/4) registers from target, wrapping modulo 32.
// - Each string register cleared first; bytes fill high to low.
// - Indexed string address is index plus base, or zero base.
// - Indexed string takes count from the transfer byte count field.
// - Zero transfer count makes indexed string a no-operation.
// - Zero transfer count raises no data-storage or TLB-miss exception.
// - Zero count may still raise machine-check on cacheable fill bus error.
// - String bytes aimed at base register are dropped unless it is final.
// - Load-and-reserve loads the word and sets the reservation flag.
// - Load-and-reserve raises alignment on an unaligned address.
// - Zone protection in user mode with relocation raises data-storage.
// - Relocation with no matching translation raises data TLB-miss.
// - Nonzero reserved bits give undefined result, no program exception.
`default_nettype none
module multi_register_load_sequencer
	import mrl_pkg::*;
#(
	parameter int FIFO_DEPTH_P = mrl_pkg::FIFO_DEPTH
) (
	input  wire logic        clk_sys_i,
	input  wire logic        rst_b_i,
	input  wire logic        instr_valid_i,
	input  wire logic [31:0] instr_i,
	output logic             instr_ready_o,
	input  wire logic [31:0] base_value_i,
	input  wire logic [31:0] index_value_i,
	input  wire logic [6:0]  transfer_byte_count_i,
	input  wire logic        user_mode_i,
	input  wire logic        data_reloc_i,
	output logic             mem_req_o,
	output logic [31:0]      mem_addr_o,
	output logic             mem_byte_o,
	input  wire logic        mem_gnt_i,
	input  wire logic        mem_zone_deny_i,
	input  wire logic        mem_tlb_miss_i,
	input  wire logic        mem_rvalid_i,
	input  wire logic [31:0] mem_rdata_i,
	input  wire logic        mem_bus_err_i,
	input  wire logic        mem_cacheable_i,
	output logic             gpr_we_o,
	output logic [4:0]       gpr_waddr_o,
	output logic [31:0]      gpr_wdata_o,
	output logic             reserve_o,
	output logic             exc_valid_o,
	output var mrl_pkg::exc_t exc_code_o,
	output logic             stall_o
);
	import mrl_pkg::*;

	typedef enum logic [2:0] {S_IDLE, S_ISSUE, S_WAIT, S_DRAIN, S_PROBE} state_t;
	typedef enum logic [1:0] {K_MULTI, K_STRING, K_RSV} kind_t;

	// ------------------------------------------------------------
	// Decode
	// ------------------------------------------------------------
	wire [5:0]  opc      = instr_i[31:26];
	wire [4:0]  tgt_fld  = instr_i[25:21];
	wire [4:0]  base_register_field = instr_i[20:16];
	wire [4:0]  index_register_field = instr_i[15:11];
	wire [4:0]  immediate_byte_count = instr_i[15:11];
	wire [9:0]  xo       = instr_i[10:1];
	wire [31:0] base_or0 = (base_register_field == 5'h00) ? 32'h0000_0000 : base_value_i;
	wire is_lm  = (opc == OP_LOAD_MULTI);
	wire is_lsi = (opc == OP_PRIMARY_X) && (xo == XO_STR_IMM);
	wire is_lsx = (opc == OP_PRIMARY_X) && (xo == XO_STR_IDX);
	wire is_rsv = (opc == OP_PRIMARY_X) && (xo == XO_LOAD_RSV);
	wire known  = is_lm | is_lsi | is_lsx | is_rsv;
	wire rsvd_bit_unused = instr_i[0];

	wire [31:0] ea_lm  = base_or0 + {{16{instr_i[15]}}, instr_i[15:0]};
	wire [31:0] ea_lsi = base_or0;
	wire [31:0] ea_idx = base_or0 + index_value_i;
	wire [6:0]  cnt_lsi = (immediate_byte_count == 5'h00) ? 7'(STR_IMM_ZERO_CNT) : {2'b00, immediate_byte_count};
	wire [6:0]  cnt_str = is_lsi ? cnt_lsi : transfer_byte_count_i;
	wire [6:0]  cnt_lm  = 7'd32 - {2'b00, tgt_fld};
	wire [4:0]  nr_m1   = 5'((cnt_str + 7'd3) / 7'd4 - 7'd1);
	wire [4:0]  fin_str = tgt_fld + nr_m1;

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	state_t     st_q;
	kind_t      kind_q;
	logic [31:0] ea_q;
	logic [6:0]  left_q;
	logic [6:0]  pend_q;
	logic [6:0]  rem_q;
	logic [4:0]  reg_q;
	logic [4:0]  base_q;
	logic [4:0]  fin_q;
	logic [1:0]  bpos_q;
	logic [31:0] acc_q;
	logic        abort_q;

	wire f_in_ready;
	wire f_out_valid;
	wire [31:0] f_out_data;
	wire f_in_valid = mem_rvalid_i && !mem_bus_err_i && !abort_q;
	wire flush = (st_q == S_IDLE);
	wire drain_word = (kind_q != K_STRING);
	wire f_pop = f_out_valid && (st_q != S_IDLE);

	mrl_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH_P)) u_fifo (
		.clk_sys_i   (clk_sys_i),
		.rst_b_i     (rst_b_i),
		.flush_i     (flush),
		.in_valid_i  (f_in_valid),
		.in_ready_o  (f_in_ready),
		.in_data_i   (mem_rdata_i),
		.out_valid_o (f_out_valid),
		.out_ready_i (f_pop),
		.out_data_o  (f_out_data)
	);

	// Request only while room is guaranteed for every outstanding answer
	wire room = ({1'b0, pend_q} + 8'd1) < 8'(FIFO_DEPTH_P);
	wire issue = (st_q == S_ISSUE) && (left_q != 7'd0) && room && f_in_ready;
	wire fire  = issue && mem_gnt_i;
	wire [6:0] step = drain_word ? 7'd4 : 7'd1;

	wire f_zone = mem_zone_deny_i && user_mode_i && data_reloc_i;
	wire f_tlb  = mem_tlb_miss_i && data_reloc_i;
	wire fault  = fire && (f_zone || f_tlb);
	// Faulted requests get no answer, so they never count as outstanding
	wire took   = fire && !fault;

	// Byte lane from current memory word
	wire [7:0] byte_in = f_out_data[7:0];
	// drop writes aimed at the base register unless it is the final register
	wire keep_reg = (reg_q != base_q) || (reg_q == fin_q);
	wire lm_done  = (reg_q == LAST_GPR);
	wire [4:0] sh = {~bpos_q, 3'b000};
	// high byte first into cleared register
	wire [31:0] acc_new = ((bpos_q == 2'd0) ? 32'h0 : acc_q) | (32'(byte_in) << sh);
	// Last string byte is the pop that leaves no byte to come
	wire str_last = (rem_q == 7'd1);

	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			st_q <= S_IDLE;
			kind_q <= K_MULTI;
			ea_q <= '0;
			left_q <= '0;
			pend_q <= '0;
			rem_q <= '0;
			reg_q <= '0;
			base_q <= '0;
			fin_q <= '0;
			bpos_q <= '0;
			acc_q <= '0;
			abort_q <= 1'b0;
			gpr_we_o <= 1'b0;
			gpr_waddr_o <= '0;
			gpr_wdata_o <= '0;
			reserve_o <= 1'b0;
			exc_valid_o <= 1'b0;
			exc_code_o <= EXC_NONE;
			mem_req_o <= 1'b0;
			mem_addr_o <= '0;
			mem_byte_o <= 1'b0;
			instr_ready_o <= 1'b0;
			stall_o <= 1'b0;
		end else begin
			gpr_we_o <= 1'b0;
			exc_valid_o <= 1'b0;
			instr_ready_o <= (st_q == S_IDLE) && !instr_valid_i;
			if (mem_rvalid_i && pend_q != 7'd0) pend_q <= pend_q - 7'd1 + 7'(took);
			else if (took) pend_q <= pend_q + 7'd1;
			mem_req_o <= 1'b0;
			case (st_q)
				S_IDLE: begin
					stall_o <= instr_valid_i && known;
					instr_ready_o <= !(instr_valid_i && known);
					if (instr_valid_i && known) begin
						base_q <= base_register_field;
						reg_q <= tgt_fld;
						bpos_q <= 2'd0;
						abort_q <= 1'b0;
						fin_q <= is_lm ? LAST_GPR : (is_rsv ? tgt_fld : fin_str);
						kind_q <= is_lm ? K_MULTI : (is_rsv ? K_RSV : K_STRING);
						ea_q <= is_lm ? ea_lm : (is_lsi ? ea_lsi : ea_idx);
						left_q <= is_lm ? cnt_lm : (is_rsv ? 7'd1 : cnt_str);
						rem_q <= is_lm ? cnt_lm : (is_rsv ? 7'd1 : cnt_str);
						if (is_rsv && ea_idx[1:0] != 2'b00) begin
							exc_valid_o <= 1'b1;
							exc_code_o <= EXC_ALIGN;
							st_q <= S_DRAIN;
							left_q <= 7'd0;
						end else if (is_lsx && transfer_byte_count_i == 7'd0) begin
							st_q <= mem_cacheable_i ? S_PROBE : S_DRAIN;
						end else begin
							st_q <= S_ISSUE;
						end
					end
				end
				S_PROBE: begin
					if (mem_bus_err_i && !f_zone && !f_tlb) begin
						exc_valid_o <= 1'b1;
						exc_code_o <= EXC_MCHECK;
					end
					st_q <= S_DRAIN;
				end
				S_ISSUE, S_WAIT: begin
					if (issue) begin
						mem_req_o <= 1'b1;
						mem_addr_o <= ea_q;
						mem_byte_o <= !drain_word;
					end
					if (fire) begin
						ea_q <= ea_q + 32'(step);
						left_q <= left_q - 7'd1;
					end
					if (fault || (mem_rvalid_i && mem_bus_err_i)) begin
						exc_valid_o <= 1'b1;
						exc_code_o <= fault ? (f_zone ? EXC_DSTORAGE : EXC_DTLB) : EXC_MCHECK;
						abort_q <= 1'b1;
						left_q <= 7'd0;
						st_q <= S_DRAIN;
					end
					if (f_pop && !abort_q) begin
						if (drain_word) begin
							gpr_we_o <= keep_reg;
							gpr_waddr_o <= reg_q;
							gpr_wdata_o <= f_out_data;
							reg_q <= reg_q + 5'd1;
							if (kind_q == K_RSV) reserve_o <= 1'b1;
							if (kind_q == K_RSV || lm_done) st_q <= S_DRAIN;
						end else begin
							acc_q <= acc_new;
							bpos_q <= bpos_q + 2'd1;
							rem_q <= rem_q - 7'd1;
							if (bpos_q == 2'd3 || str_last) begin
								gpr_we_o <= keep_reg;
								gpr_waddr_o <= reg_q;
								gpr_wdata_o <= acc_new;
								reg_q <= reg_q + 5'd1;
								if (reg_q == fin_q) st_q <= S_DRAIN;
							end
						end
					end
				end
				S_DRAIN: begin
					if (pend_q == 7'd0 && !mem_rvalid_i) begin
						st_q <= S_IDLE;
						stall_o <= 1'b0;
					end
				end
				default: st_q <= S_IDLE;
			endcase
		end
	end

	wire unused_ok = rsvd_bit_unused & index_register_field[0];

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	sequence s_rsv_word;
		f_pop && !abort_q && kind_q == K_RSV && st_q != S_DRAIN;
	endsequence
	chk_reserve_set: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		s_rsv_word |=> reserve_o && gpr_we_o) else $error("reserve not set");
	chk_align_fault: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		st_q == S_IDLE && instr_valid_i && is_rsv && ea_idx[1:0] != 2'b00
		|=> exc_valid_o && exc_code_o == EXC_ALIGN) else $error("no alignment fault");
	chk_zero_noop: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		st_q == S_IDLE && instr_valid_i && is_lsx && transfer_byte_count_i == 7'd0
		|=> !mem_req_o ##1 !mem_req_o && !gpr_we_o) else $error("zero count not a no-op");
	// no storage fault on zero count
	chk_zero_nofault: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		st_q == S_IDLE && instr_valid_i && is_lsx && transfer_byte_count_i == 7'd0
		|=> !(exc_valid_o && exc_code_o inside {EXC_DSTORAGE, EXC_DTLB})) else $error("fault on zero count");
	chk_lm_step: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		fire && kind_q == K_MULTI && !fault |=> ea_q == $past(ea_q) + 32'd4) else $error("bad address step");
	chk_base_drop: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		gpr_we_o |-> (gpr_waddr_o != base_q) || (gpr_waddr_o == fin_q)) else $error("base register written");
	chk_zone_fault: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		fire && f_zone |=> exc_valid_o && exc_code_o == EXC_DSTORAGE) else $error("no data-storage fault");
	chk_tlb_fault: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		fire && f_tlb && !f_zone |=> exc_valid_o && exc_code_o == EXC_DTLB) else $error("no tlb fault");
	chk_stall_busy: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		st_q inside {S_ISSUE, S_WAIT} |-> stall_o) else $error("not stalled");
	sequence s_str_tail;
		f_pop && !abort_q && kind_q == K_STRING && st_q inside {S_ISSUE, S_WAIT} && str_last && keep_reg;
	endsequence
	sequence s_lm_tail;
		f_pop && !abort_q && kind_q == K_MULTI && st_q inside {S_ISSUE, S_WAIT} && lm_done;
	endsequence
	chk_str_tail_write: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		s_str_tail |=> gpr_we_o && gpr_waddr_o == $past(reg_q)) else $error("final string register not written");
	chk_str_final_end: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		gpr_we_o && kind_q == K_STRING && gpr_waddr_o == fin_q |-> st_q == S_DRAIN)
		else $error("string ran past final register");
	chk_lm_last_reg: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		s_lm_tail |=> gpr_we_o && gpr_waddr_o == LAST_GPR) else $error("register 31 not written");
	chk_probe_mcheck: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		st_q == S_PROBE && mem_bus_err_i && !f_zone && !f_tlb |=> exc_valid_o && exc_code_o == EXC_MCHECK)
		else $error("no machine check on probe");
	chk_pend_bound: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		pend_q < 7'(FIFO_DEPTH_P)) else $error("too many outstanding requests");
	chk_idle_quiet: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		st_q == S_IDLE |-> !mem_req_o && !gpr_we_o) else $error("activity while idle");
endmodule // multi_register_load_sequencer
`default_nettype wire

// ### tb/mrl_mem_model.sv
// Behavioural data memory port answering the load sequencer
`default_nettype none
module mrl_mem_model (
	input  wire logic        clk_sys_i,
	input  wire logic        rst_b_i,
	input  wire logic        req_i,
	input  wire logic [31:0] addr_i,
	input  wire logic        byte_i,
	input  wire logic [3:0]  lat_i,
	input  wire logic        deny_en_i,
	input  wire logic        miss_en_i,
	input  wire logic        berr_en_i,
	input  wire logic        cache_en_i,
	output logic             gnt_o,
	output logic             deny_o,
	output logic             miss_o,
	output logic             rvalid_o,
	output logic [31:0]      rdata_o,
	output logic             berr_o,
	output logic             cacheable_o
);
	timeunit 1ns;
	timeprecision 1ps;
	int          cyc;
	int          due[$];
	logic [32:0] pend[$];
	function automatic logic [7:0] mb(input logic [31:0] a);
		return a[7:0] ^ 8'h3c;
	endfunction
	function automatic logic [31:0] mw(input logic [31:0] a);
		return {mb(a), mb(a + 1), mb(a + 2), mb(a + 3)};
	endfunction
	// Always ready: the sequencer samples grant and faults in its issue cycle
	assign gnt_o       = 1'b1;
	assign deny_o      = deny_en_i;
	assign miss_o      = miss_en_i;
	assign berr_o      = berr_en_i;
	assign cacheable_o = cache_en_i;
	// Answers after lat_i cycles; data line toggles when idle
	always @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cyc      = 0;
			rvalid_o <= 1'b0;
			rdata_o  <= 32'h0;
			due.delete();
			pend.delete();
		end else begin
			rvalid_o <= 1'b0;
			rdata_o  <= ~rdata_o;
			if (due.size() > 0 && due[0] <= cyc) begin
				rvalid_o <= 1'b1;
				rdata_o  <= pend[0][32] ? {{3{~mb(pend[0][31:0])}}, mb(pend[0][31:0])} : mw(pend[0][31:0]);
				void'(due.pop_front());
				void'(pend.pop_front());
			end
			if (req_i && !deny_o && !miss_o) begin
				due.push_back(cyc + int'(lat_i));
				pend.push_back({byte_i, addr_i});
			end
			cyc = cyc + 1;
		end
	end
endmodule // mrl_mem_model
`default_nettype wire

// ### tb/multi_register_load_sequencer_test.sv
// Self-checking bench for the multi-register load sequencer
`default_nettype none
module multi_register_load_sequencer_test;
	timeunit 1ns;
	timeprecision 1ps;
	import mrl_pkg::*;
	logic        clk_sys_i, rst_b_i, instr_valid_i, instr_ready_o, user_mode_i, data_reloc_i;
	logic [31:0] instr_i, base_value_i, index_value_i, mem_addr_o, mem_rdata_i, gpr_wdata_o;
	logic [6:0]  transfer_byte_count_i;
	logic        mem_req_o, mem_byte_o, mem_gnt_i, mem_zone_deny_i, mem_tlb_miss_i, mem_rvalid_i;
	logic        mem_bus_err_i, mem_cacheable_i, gpr_we_o, reserve_o, exc_valid_o, stall_o;
	logic [4:0]  gpr_waddr_o;
	exc_t        exc_code_o, exc_seen;
	logic [3:0]  lat;
	logic        deny, miss, berr, cache;
	logic [4:0]  er[$], gr[$];
	logic [31:0] ed[$], gd[$], ins;
	int          num_errors, n_tests;
	multi_register_load_sequencer i_multi_register_load_sequencer (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
		.instr_valid_i(instr_valid_i), .instr_i(instr_i), .instr_ready_o(instr_ready_o),
		.base_value_i(base_value_i), .index_value_i(index_value_i), .transfer_byte_count_i(transfer_byte_count_i),
		.user_mode_i(user_mode_i), .data_reloc_i(data_reloc_i), .mem_req_o(mem_req_o), .mem_addr_o(mem_addr_o),
		.mem_byte_o(mem_byte_o), .mem_gnt_i(mem_gnt_i), .mem_zone_deny_i(mem_zone_deny_i),
		.mem_tlb_miss_i(mem_tlb_miss_i), .mem_rvalid_i(mem_rvalid_i), .mem_rdata_i(mem_rdata_i),
		.mem_bus_err_i(mem_bus_err_i), .mem_cacheable_i(mem_cacheable_i), .gpr_we_o(gpr_we_o),
		.gpr_waddr_o(gpr_waddr_o), .gpr_wdata_o(gpr_wdata_o), .reserve_o(reserve_o),
		.exc_valid_o(exc_valid_o), .exc_code_o(exc_code_o), .stall_o(stall_o));
	mrl_mem_model i_mrl_mem_model (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .req_i(mem_req_o),
		.addr_i(mem_addr_o), .byte_i(mem_byte_o), .lat_i(lat), .deny_en_i(deny), .miss_en_i(miss),
		.berr_en_i(berr), .cache_en_i(cache), .gnt_o(mem_gnt_i), .deny_o(mem_zone_deny_i),
		.miss_o(mem_tlb_miss_i), .rvalid_o(mem_rvalid_i), .rdata_o(mem_rdata_i), .berr_o(mem_bus_err_i),
		.cacheable_o(mem_cacheable_i));
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [7:0] mb(input logic [31:0] a);
		return a[7:0] ^ 8'h3c;
	endfunction
	function automatic logic [31:0] mw(input logic [31:0] a);
		return {mb(a), mb(a + 1), mb(a + 2), mb(a + 3)};
	endfunction
	function automatic logic [31:0] xf(input int rd, input int ra, input int rb, input logic [9:0] xo);
		return {OP_PRIMARY_X, 5'(rd), 5'(ra), 5'(rb), xo, 1'b0};
	endfunction
	task automatic close_out();
		$display("TB: errors %0d checks %0d", num_errors, n_tests);
		if (num_errors == 0 && n_tests > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic lmw_x(input int rd, input int ra, input logic [31:0] ea);
		for (int n = rd; n <= 31; n++) begin
			if (n != ra || n == 31) begin
				er.push_back(5'(n));
				ed.push_back(mw(ea));
			end
			ea += 4;
		end
	endtask
	task automatic str_x(input int rd, input int ra, input int n, input logic [31:0] ea);
		int          nr;
		int          r;
		logic [31:0] v;
		nr = (n + 3) / 4;
		for (int k = 0; k < nr; k++) begin
			r = (rd + k) % 32;
			v = 32'h0;
			for (int j = 0; j < 4; j++)
				if (4 * k + j < n) v[31 - 8 * j -: 8] = mb(ea + 4 * k + j);
			if (r != ra || k == nr - 1) begin
				er.push_back(5'(r));
				ed.push_back(v);
			end
		end
	endtask
	task automatic run(input logic [31:0] i, input logic [31:0] bv, input logic [31:0] iv, input logic [6:0] tc);
		int k;
		gr.delete();
		gd.delete();
		exc_seen = EXC_NONE;
		@(negedge clk_sys_i);
		chk("ready", 32'h1, {31'h0, instr_ready_o});
		instr_i = i;
		base_value_i = bv;
		index_value_i = iv;
		transfer_byte_count_i = tc;
		instr_valid_i = 1'b1;
		@(negedge clk_sys_i);
		instr_valid_i = 1'b0;
		chk("ready", 32'h0, {31'h0, instr_ready_o});
		if (er.size() > 0) chk("stall", 32'h1, {31'h0, stall_o});
		k = 0;
		while (stall_o !== 1'b0 && k < 500) begin
			@(negedge clk_sys_i);
			k++;
		end
		if (k == 500) begin
			num_errors++;
			close_out();
		end
		repeat (2) @(negedge clk_sys_i);
		chk("count", 32'(er.size()), 32'(gr.size()));
		foreach (er[n])
			if (n < gr.size()) begin
				chk("waddr", {27'h0, er[n]}, {27'h0, gr[n]});
				chk("wdata", ed[n], gd[n]);
			end
		er.delete();
		ed.delete();
	endtask
	// ----------------------------------------
	// Clock, monitor and sequence
	// ----------------------------------------
	initial begin
		clk_sys_i = 1'b0;
		forever #2.5 clk_sys_i = ~clk_sys_i;
	end
	always @(posedge clk_sys_i) begin
		if (gpr_we_o === 1'b1) begin
			gr.push_back(gpr_waddr_o);
			gd.push_back(gpr_wdata_o);
		end
		if (exc_valid_o === 1'b1) exc_seen <= exc_code_o;
	end
	initial begin
		{rst_b_i, instr_valid_i, user_mode_i, data_reloc_i, deny, miss, berr, cache} = '0;
		{instr_i, base_value_i, index_value_i, transfer_byte_count_i} = '0;
		{num_errors, n_tests} = '0;
		exc_seen = EXC_NONE;
		lat = 4'h1;
		repeat (3) @(negedge clk_sys_i);
		rst_b_i = 1'b1;
		chk("reserve", 32'h0, {31'h0, reserve_o});
		lmw_x(29, 3, 32'hf8);
		run({OP_LOAD_MULTI, 5'd29, 5'd3, 16'hfff8}, 32'h100, 32'h0, 7'h0);
		lmw_x(29, 30, 32'h210);
		run({OP_LOAD_MULTI, 5'd29, 5'd30, 16'h0010}, 32'h200, 32'h0, 7'h0);
		lmw_x(30, 0, 32'h40);
		run({OP_LOAD_MULTI, 5'd30, 5'd0, 16'h0040}, 32'hdead0000, 32'h0, 7'h0);
		lat = 4'h3;
		str_x(31, 0, 32, 32'h0);
		run(xf(31, 0, 0, XO_STR_IMM), 32'h12345678, 32'h0, 7'h0);
		str_x(5, 2, 6, 32'h41);
		run(xf(5, 2, 6, XO_STR_IMM), 32'h41, 32'h0, 7'h0);
		str_x(5, 6, 5, 32'h60);
		run(xf(5, 6, 5, XO_STR_IMM), 32'h60, 32'h0, 7'h0);
		str_x(5, 5, 9, 32'h93);
		run(xf(5, 5, 1, XO_STR_IDX), 32'h80, 32'h13, 7'h09);
		{user_mode_i, data_reloc_i, deny, miss} = 4'hf;
		run(xf(8, 1, 2, XO_STR_IDX), 32'h100, 32'h0, 7'h0);
		chk("exc", 32'(EXC_NONE), 32'(exc_seen));
		{deny, miss, berr, cache} = 4'h3;
		run(xf(8, 1, 2, XO_STR_IDX), 32'h100, 32'h0, 7'h0);
		chk("exc", 32'(EXC_MCHECK), 32'(exc_seen));
		{berr, lat} = {1'b0, 4'h1};
		er.push_back(5'd9);
		ed.push_back(mw(32'h304));
		run(xf(9, 1, 2, XO_LOAD_RSV), 32'h300, 32'h4, 7'h0);
		chk("reserve", 32'h1, {31'h0, reserve_o});
		er.push_back(5'd9);
		ed.push_back(mw(32'h304));
		run(xf(9, 1, 2, XO_LOAD_RSV) | 32'h1, 32'h300, 32'h4, 7'h0);
		chk("exc", 32'(EXC_NONE), 32'(exc_seen));
		run(xf(9, 1, 2, XO_LOAD_RSV), 32'h300, 32'h6, 7'h0);
		chk("exc", 32'(EXC_ALIGN), 32'(exc_seen));
		for (int m = 0; m < 3; m++) begin
			ins = m == 0 ? {OP_LOAD_MULTI, 5'd28, 5'd1, 16'h0} : m == 1 ? xf(4, 1, 4, XO_STR_IMM) : xf(4, 1, 2, XO_LOAD_RSV);
			deny = 1'b1;
			run(ins, 32'h400, 32'h0, 7'h0);
			chk("exc", 32'(EXC_DSTORAGE), 32'(exc_seen));
			{deny, miss} = 2'b01;
			run(ins, 32'h400, 32'h0, 7'h0);
			chk("exc", 32'(EXC_DTLB), 32'(exc_seen));
			miss = 1'b0;
		end
		close_out();
	end
endmodule // multi_register_load_sequencer_test
`default_nettype wire
